// File: design/area_code_pkg.sv
// Shared constants and types for the burst cut area code formatter
package area_code_pkg;

  // Channel word pieces
  localparam logic [7:0] SYNC_PATTERN = 8'h46;
  localparam logic [3:0] SYNC_CODE = 4'h0;
  localparam logic [3:0] RESYNC_PARITY = 4'hD;
  localparam logic [3:0] RESYNC_POST_LEAD = 4'hE;
  localparam logic [3:0] RESYNC_POST_TAIL = 4'hF;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0] POSTAMBLE_BYTE = 8'h55;

  // Codes: x^32 term implied, x^8 term implied
  localparam logic [31:0] EDC_POLY = 32'h80000011;
  localparam logic [31:0] EDC_RESET = 32'h00000000;
  localparam logic [7:0] GF_POLY = 8'h1D;
  localparam logic [5:0] RS_TOP_SHIFT = 6'h30;

  // Framing geometry
  localparam logic [3:0] N_MAX = 4'hC;
  localparam logic [2:0] SLOTS_PER_ROW = 3'h5;
  localparam logic [3:0] CB_PER_SLOT_LAST = 4'hF;
  localparam logic [5:0] ROWS_AFTER_DATA = 6'h06;

  typedef enum logic [0:0] {
    FMT_IDLE,
    FMT_SEND
  } fmt_state_type;

  typedef struct packed {
    logic clear;
    logic info_we;
    logic [1:0] lane;
    logic [7:0] data;
    logic d_load;
    logic [5:0] zero_count;
  } feed_type;

  typedef struct packed {
    logic [31:0] edc;
    logic [3:0][3:0][7:0] parity;
  } check_type;

endpackage

// File: design/area_check_gen.sv
// Detection code and interleaved parity generator for the code block
`timescale 1ns/1ps
module area_check_gen (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input area_code_pkg::feed_type feed_i,
  output area_code_pkg::check_type check_o
);
  import area_code_pkg::*;

  typedef struct packed {
    logic [31:0] edc;
    logic [3:0][3:0][7:0] par;
    logic [5:0] zcnt;
  } gen_state_type;

  gen_state_type state_ff;
  gen_state_type nxt_state;

  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) begin
        p = p ^ x;
      end
      x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY) : {x[6:0], 1'b0};
    end
    return p;
  endfunction

  // Product of (x + alpha^k), k = 0..3, low four coefficients
  function automatic logic [3:0][7:0] rs_gen();
    logic [4:0][7:0] g;
    logic [7:0] root;
    g = '0;
    g[0] = 8'h01;
    root = 8'h01;
    for (int k = 0; k < 4; k++) begin
      for (int d = 4; d > 0; d--) begin
        g[d] = g[d-1] ^ gf_mul(g[d], root);
      end
      g[0] = gf_mul(g[0], root);
      root = gf_mul(root, 8'h02);
    end
    return g[3:0];
  endfunction

  localparam logic [3:0][7:0] RS_GEN = rs_gen();

  function automatic logic [31:0] edc_byte(input logic [31:0] c, input logic [7:0] d);
    logic fb;
    for (int b = 7; b >= 0; b--) begin
      fb = c[31] ^ d[b];
      c = {c[30:0], 1'b0} ^ (fb ? EDC_POLY : 32'h00000000);
    end
    return c;
  endfunction

  // Index 3 holds the highest degree remainder coefficient
  function automatic logic [3:0][7:0] rs_step(input logic [3:0][7:0] r, input logic [7:0] d);
    logic [7:0] f;
    logic [3:0][7:0] q;
    f = d ^ r[3];
    for (int k = 3; k > 0; k--) begin
      q[k] = r[k-1] ^ gf_mul(f, RS_GEN[k]);
    end
    q[0] = gf_mul(f, RS_GEN[0]);
    return q;
  endfunction

  always_comb begin
    nxt_state = state_ff;
    if (feed_i.clear) begin
      nxt_state = '0;
      nxt_state.edc = EDC_RESET;
    end else begin
      if (feed_i.info_we) begin
        nxt_state.edc = edc_byte(state_ff.edc, feed_i.data);
        nxt_state.par[feed_i.lane] = rs_step(state_ff.par[feed_i.lane], feed_i.data);
      end
      if (feed_i.d_load) begin
        for (int j = 0; j < 4; j++) begin
          nxt_state.par[j] = rs_step(state_ff.par[j], state_ff.edc[31-8*j -: 8]);
        end
        nxt_state.zcnt = feed_i.zero_count;
      end else if (state_ff.zcnt != 6'h00) begin
        // Zero steps place the message at its true degree before the remainder
        for (int j = 0; j < 4; j++) begin
          nxt_state.par[j] = rs_step(state_ff.par[j], 8'h00);
        end
        nxt_state.zcnt = state_ff.zcnt - 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign check_o = {state_ff.edc, state_ff.par};

endmodule

// File: design/burst_area_code_formatter.sv
// Burst cut area code block framer with phase encoding and RZ pulse output
//
// What this block does
// - Protected data bit zero goes out as channel bits 01, one as 10.
// - Outside protected data, polarity inverts: zero is 10, one is 01.
// - Normal polarity only for information, detection and parity bytes.
// - Channel train is RZ; each pulse lasts at most half a channel bit.
// - Preamble, data field, postamble follow back to back without gaps.
// - Preamble is the sync byte then four bytes of 00 hex.
// - Data: 16n-4 information bytes, D0..D3, then C00..C33; n is 1..12.
// - A resync word precedes every group of four data field bytes.
// - Postamble is four 55 hex bytes with a resync before and after.
// - Detection bits numbered from last check byte LSB; info at 32 up.
// - Check bytes are the info polynomial mod x^32+x^31+x^4+1.
// - Four interleaves; interleave j takes bytes with index mod 4 = j, plus Dj.
// - Info byte I(j+4i) at x^(51-i), Dj at x^(52-4n); Cj,i at x^(3-i).
// - Parity is message mod product of (x+alpha^k), k 0..3, in GF(256).
// - Sync/resync: fixed 01000110 in raw RZ, then 4-bit code 0, group i, D (parity), E or F (postamble).
// - Resync words also precede detection bytes and parity bytes.
`timescale 1ns/1ps
module burst_area_code_formatter (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [3:0] n_i,
  input wire logic [7:0] info_byte_i,
  output logic [7:0] info_index_o,
  output logic pulse_o,
  output logic chan_bit_o,
  output logic protected_o,
  output logic busy_o,
  output logic done_o
);
  import area_code_pkg::*;

  typedef struct packed {
    fmt_state_type st;
    logic phase;
    logic [3:0] cb;
    logic [2:0] slot;
    logic [5:0] row;
    logic [3:0] n;
    logic [15:0] chan;
    logic prot;
    logic [7:0] idx;
    logic pulse;
    logic bit_out;
    logic done;
  } fmt_reg_type;

  fmt_reg_type state_ff;
  fmt_reg_type nxt_state;
  feed_type feed;
  check_type check;
  logic [5:0] data_rows;
  logic [5:0] nxt_row;
  logic [2:0] nxt_slot;
  logic slot_end;
  logic last_slot;

  // Phase encode a byte MSB first; inv selects the non-data polarity
  function automatic logic [15:0] pe_word(input logic [7:0] b, input logic inv);
    logic [15:0] w;
    w = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      w[15-2*k] = b[7-k] ^ inv;
      w[14-2*k] = ~b[7-k] ^ inv;
    end
    return w;
  endfunction

  function automatic logic [3:0] resync_code(input logic [5:0] row, input logic [5:0] drows);
    logic [5:0] grp;
    grp = 6'h00;
    if (row == 6'h00) begin
      resync_code = SYNC_CODE;
    end else if (row <= drows) begin
      grp = ((row - 6'h01) >> 2) + 6'h01;
      resync_code = grp[3:0];
    end else if (row <= drows + 6'h04) begin
      resync_code = RESYNC_PARITY;
    end else if (row == drows + 6'h05) begin
      resync_code = RESYNC_POST_LEAD;
    end else begin
      resync_code = RESYNC_POST_TAIL;
    end
  endfunction

  area_check_gen u_check (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .feed_i(feed),
    .check_o(check)
  );

  assign data_rows = {state_ff.n, 2'b00};
  assign slot_end = state_ff.phase && (state_ff.cb == CB_PER_SLOT_LAST);
  assign last_slot = (state_ff.slot == SLOTS_PER_ROW - 3'h1)
                     || (state_ff.row == data_rows + ROWS_AFTER_DATA);

  always_comb begin
    nxt_slot = state_ff.slot + 3'h1;
    nxt_row = state_ff.row;
    if (last_slot) begin
      nxt_slot = 3'h0;
      nxt_row = state_ff.row + 6'h01;
    end
  end

  always_comb begin
    logic [5:0] wrow;
    logic [2:0] wslot;
    logic [5:0] drows;
    logic [15:0] code_word;
    logic [1:0] pidx;
    logic [1:0] prow;
    logic load;
    wrow = 6'h00;
    wslot = 3'h0;
    drows = data_rows;
    code_word = 16'h0000;
    pidx = 2'h0;
    prow = 2'h0;
    load = 1'b0;
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    feed = '0;

    case (state_ff.st)
      FMT_IDLE: begin
        // An n outside 1..12 is ignored rather than framed wrongly
        if (start_i && (n_i != 4'h0) && (n_i <= N_MAX)) begin
          nxt_state.st = FMT_SEND;
          nxt_state.n = n_i;
          nxt_state.row = 6'h00;
          nxt_state.slot = 3'h0;
          nxt_state.cb = 4'h0;
          nxt_state.phase = 1'b0;
          nxt_state.idx = 8'h00;
          drows = {n_i, 2'b00};
          feed.clear = 1'b1;
          load = 1'b1;
        end
      end
      FMT_SEND: begin
        nxt_state.phase = ~state_ff.phase;
        if (state_ff.phase) begin
          nxt_state.cb = state_ff.cb + 4'h1;
          nxt_state.chan = {state_ff.chan[14:0], 1'b0};
        end
        if (slot_end) begin
          if (state_ff.row == data_rows + ROWS_AFTER_DATA) begin
            nxt_state.st = FMT_IDLE;
            nxt_state.done = 1'b1;
            nxt_state.prot = 1'b0;
          end else begin
            nxt_state.slot = nxt_slot;
            nxt_state.row = nxt_row;
            load = 1'b1;
          end
        end
      end
      default: begin
        nxt_state.st = FMT_IDLE;
      end
    endcase

    if (load) begin
      wrow = nxt_state.row;
      wslot = nxt_state.slot;
      nxt_state.prot = 1'b0;
      if (wslot == 3'h0) begin
        // Fixed part goes out raw, code part phase encoded inverted
        code_word = pe_word({resync_code(wrow, drows), 4'h0}, 1'b1);
        nxt_state.chan = {SYNC_PATTERN, code_word[15:8]};
        if (wrow == drows) begin
          feed.d_load = 1'b1;
          feed.zero_count = RS_TOP_SHIFT - drows;
        end
      end else if (wrow == 6'h00) begin
        nxt_state.chan = pe_word(PREAMBLE_BYTE, 1'b1);
      end else if (wrow < drows) begin
        nxt_state.chan = pe_word(info_byte_i, 1'b0);
        nxt_state.prot = 1'b1;
        nxt_state.idx = state_ff.idx + 8'h01;
        feed.info_we = 1'b1;
        feed.lane = state_ff.idx[1:0];
        feed.data = info_byte_i;
      end else if (wrow == drows) begin
        pidx = 2'(wslot - 3'h1);
        nxt_state.chan = pe_word(check.edc[31 - 8*pidx -: 8], 1'b0);
        nxt_state.prot = 1'b1;
      end else if (wrow <= drows + 6'h04) begin
        prow = 2'(wrow - drows - 6'h01);
        pidx = 2'(3'h4 - wslot);
        nxt_state.chan = pe_word(check.parity[prow][pidx], 1'b0);
        nxt_state.prot = 1'b1;
      end else begin
        nxt_state.chan = pe_word(POSTAMBLE_BYTE, 1'b1);
      end
    end

    nxt_state.bit_out = (nxt_state.st == FMT_SEND) && nxt_state.chan[15];
    // Pulse only in the first half clock of a channel bit
    nxt_state.pulse = nxt_state.bit_out && !nxt_state.phase;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= '0;
      state_ff.st <= FMT_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign info_index_o = state_ff.idx;
  assign pulse_o = state_ff.pulse;
  assign chan_bit_o = state_ff.bit_out;
  assign protected_o = state_ff.prot;
  assign busy_o = (state_ff.st == FMT_SEND);
  assign done_o = state_ff.done;

endmodule

// File: tb/area_fmt_asserts.sv
// Port assertions for the code block formatter
`timescale 1ns/1ps
module area_fmt_asserts (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [3:0] n_i,
  input wire logic [7:0] info_byte_i,
  input wire logic [7:0] info_index_o,
  input wire logic pulse_o,
  input wire logic chan_bit_o,
  input wire logic protected_o,
  input wire logic busy_o,
  input wire logic done_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = start_i && !busy_o && n_i >= 4'h1 && n_i <= 4'hC;
  a_pulse_half: assert property (pulse_o |=> !pulse_o)
    else $error("pulse longer than half a bit");
  a_pulse_mark: assert property (pulse_o |-> chan_bit_o)
    else $error("pulse on a zero channel bit");
  a_rise_pulse: assert property ($rose(chan_bit_o) |-> pulse_o)
    else $error("one bit without pulse in first half");
  // A one bit must stand through its second half as well
  a_bit_hold: assert property (pulse_o |=> chan_bit_o)
    else $error("channel bit dropped in second half");
  a_start_taken: assert property (take |=> busy_o && info_index_o == 8'h00)
    else $error("valid start not taken");
  a_bad_size: assert property (start_i && !busy_o && (n_i == 4'h0 || n_i > 4'hC)
    |=> !busy_o)
    else $error("start with bad size taken");
  a_sync_lead: assert property (take |=> !chan_bit_o [*2] ##1 chan_bit_o [*2] ##1
    !chan_bit_o [*6] ##1 chan_bit_o)
    else $error("fixed sync pattern wrong");
  // Six slots (preamble row plus the first resync) pass before the first protected byte
  a_preamble_open: assert property (take |-> ##192 !protected_o ##1 protected_o)
    else $error("protected window misplaced");
  a_done_fall: assert property (done_o == $fell(busy_o))
    else $error("done not tied to end of block");
  a_idle_quiet: assert property (!busy_o |-> !chan_bit_o && !protected_o)
    else $error("activity while idle");
  a_index_step: assert property ($changed(info_index_o) |->
    info_index_o == $past(info_index_o) + 8'h01 || info_index_o == 8'h00)
    else $error("info index skipped");
endmodule

bind burst_area_code_formatter area_fmt_asserts chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .start_i(start_i), .n_i(n_i), .info_byte_i(info_byte_i), .info_index_o(info_index_o),
  .pulse_o(pulse_o), .chan_bit_o(chan_bit_o), .protected_o(protected_o), .busy_o(busy_o),
  .done_o(done_o));

// File: tb/stripe_writer_model.sv
// Stripe writer model recording one mark per channel bit
`timescale 1ns/1ps
module stripe_writer_model (
  input wire logic core_clk_i,
  input wire logic busy_o,
  input wire logic pulse_o,
  input wire logic protected_o
);
  logic [1:0] q[$];
  logic ph = 1'b0;
  // Only the first half of a bit is looked at; a late pulse is lost
  always @(posedge core_clk_i) begin
    if (busy_o) begin
      ph <= !ph;
      if (!ph) q.push_back({protected_o, pulse_o});
    end else begin
      ph <= 1'b0;
    end
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the code block formatter
`timescale 1ns/1ps
module testbench;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [3:0] n_i = 4'h1;
  logic [7:0] info_byte_i = 8'h00;
  logic [7:0] info_index_o;
  logic pulse_o, chan_bit_o, protected_o, busy_o, done_o;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [1:0] exp_q[$];
  logic [7:0] dat[192];
  logic [7:0] g[5];
  logic [7:0] ak;
  burst_area_code_formatter dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i),
    .n_i(n_i), .info_byte_i(info_byte_i), .info_index_o(info_index_o), .pulse_o(pulse_o),
    .chan_bit_o(chan_bit_o), .protected_o(protected_o), .busy_o(busy_o), .done_o(done_o));
  stripe_writer_model rd (.core_clk_i(core_clk_i), .busy_o(busy_o), .pulse_o(pulse_o),
    .protected_o(protected_o));
  initial begin
    forever #50 core_clk_i = !core_clk_i;
  end
  always @(posedge core_clk_i) info_byte_i <= dat[info_index_o];
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      results();
    end
  end
  task fail(input string m);
    errors++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p ^= a;
      a = a[7] ? (a << 1) ^ 8'h1D : a << 1;
    end
    return p;
  endfunction
  task put(input logic [7:0] v, input int nb, input logic pr, input logic raw);
    for (int i = nb - 1; i >= 0; i--) begin
      if (raw) exp_q.push_back({1'b0, v[i]});
      else begin
        exp_q.push_back({pr, v[i] ~^ pr});
        exp_q.push_back({pr, v[i] ^ pr});
      end
    end
  endtask
  task sync(input logic [3:0] c);
    put(8'h46, 8, 1'b0, 1'b1);
    put({4'h0, c}, 4, 1'b0, 1'b0);
  endtask
  task build(input int n);
    logic [31:0] crc;
    logic [7:0] rem[4];
    logic [7:0] t;
    crc = 32'h00000000;
    for (int k = 0; k < 16 * n - 4; k++) begin
      dat[k] = 8'(k * 29 + n);
      for (int b = 7; b >= 0; b--) begin
        t[0] = crc[31] ^ dat[k][b];
        crc = crc << 1;
        if (t[0]) crc ^= 32'h80000011;
      end
    end
    for (int j = 0; j < 4; j++) dat[16 * n - 4 + j] = crc[31 - 8 * j -: 8];
    sync(4'h0);
    repeat (4) put(8'h00, 8, 1'b0, 1'b0);
    for (int r = 0; r < 4 * n; r++) begin
      sync(4'(r / 4 + 1));
      for (int s = 0; s < 4; s++) put(dat[4 * r + s], 8, 1'b1, 1'b0);
    end
    for (int j = 0; j < 4; j++) begin
      rem = '{default: 8'h00};
      for (int s = 0; s < 52; s++) begin
        t = rem[3];
        for (int i = 3; i > 0; i--) rem[i] = rem[i - 1] ^ gm(t, g[i]);
        rem[0] = (s < 4 * n ? dat[j + 4 * s] : 8'h00) ^ gm(t, g[0]);
      end
      sync(4'hD);
      for (int i = 0; i < 4; i++) put(rem[3 - i], 8, 1'b1, 1'b0);
    end
    sync(4'hE);
    repeat (4) put(8'h55, 8, 1'b0, 1'b0);
    sync(4'hF);
  endtask
  task blocks(input logic [3:0] n, input int cnt);
    int k;
    rd.q.delete();
    exp_q.delete();
    repeat (cnt) build(n);
    start_i <= 1'b1;
    n_i <= n;
    // Start stays high so the next block must follow in the done cycle
    for (int b = 0; b < cnt; b++) begin
      k = 0;
      while (busy_o !== 1'b1 && k < 9) begin @(posedge core_clk_i); k++; end
      if (b == cnt - 1) start_i <= 1'b0;
      k = 0;
      while (done_o !== 1'b1 && k < 9000) begin @(posedge core_clk_i); k++; end
    end
    @(posedge core_clk_i);
    n_compared++;
    if (rd.q.size() != exp_q.size()) fail("block length");
    foreach (exp_q[i]) if (rd.q[i] !== exp_q[i]) begin fail("channel bit"); break; end
  endtask
  task refused();
    for (int v = 13; v < 17; v++) begin
      start_i <= 1'b1;
      n_i <= 4'(v);
      repeat (3) @(posedge core_clk_i);
      n_compared++;
      if (busy_o !== 1'b0) fail("bad size taken");
    end
    start_i <= 1'b0;
    // Let the release settle before the next task raises start again
    @(posedge core_clk_i);
  endtask
  task mid_reset();
    start_i <= 1'b1;
    n_i <= 4'h2;
    repeat (300) @(posedge core_clk_i);
    rst_i <= 1'b1;
    start_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    n_compared++;
    if ({busy_o, chan_bit_o, pulse_o, protected_o, done_o, info_index_o} !== 13'h0000)
      fail("reset state");
    rst_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task results();
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    ak = 8'h01;
    g = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 4; k++) begin
      for (int i = 4; i > 0; i--) g[i] = g[i - 1] ^ gm(g[i], ak);
      g[0] = gm(g[0], ak);
      ak = gm(ak, 8'h02);
    end
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    refused();
    blocks(4'h1, 1);
    blocks(4'hC, 2);
    mid_reset();
    blocks(4'h5, 1);
    results();
  end
endmodule
